// *** rtl/isc_pkg.sv ***
// package of constants for the instruction state counter
package isc_pkg;
  // cycle categories
  typedef enum logic [2:0] {
    ISC_FETCH,
    ISC_BRANCH_READ,
    ISC_STACK_OP,
    ISC_BYTE_ACCESS,
    ISC_WORD_ACCESS,
    ISC_INTERNAL_OP
  } isc_cat_t;
  localparam int ISC_NUM_CAT = 6;
  localparam int ISC_CNT_W = 4;
  localparam int ISC_STATES_W = 8;
  // state costs per cycle
  localparam logic [1:0] ISC_COST_MEM = 2'h2;
  localparam logic [1:0] ISC_COST_PERIPH_FAST = 2'h2;
  localparam logic [1:0] ISC_COST_PERIPH_SLOW = 2'h3;
  localparam logic [1:0] ISC_COST_INTERNAL = 2'h1;
  // opcode page decode fields
  localparam logic [7:0] ISC_OP_REG_IND_LO = 8'h7C;
  localparam logic [7:0] ISC_OP_REG_IND_HI = 8'h7D;
  localparam logic [7:0] ISC_OP_ABS_LO = 8'h7E;
  localparam logic [7:0] ISC_OP_ABS_HI = 8'h7F;
  localparam int ISC_REG_FIELD_MSB = 7;
  localparam int ISC_REG_FIELD_LSB = 4;
  localparam int ISC_SELECT_BIT = 7;
endpackage

// *** rtl/isc_decode.sv ***
// opcode page decoder for bit-manipulation operand selection
module isc_decode (
  input wire logic [7:0] first_byte, // opcode first byte
  input wire logic [7:0] second_byte, // opcode second byte
  input wire logic [7:0] fourth_byte, // opcode fourth byte
  output logic is_reg_indirect, // register-indirect form
  output logic is_absolute, // absolute-address form
  output logic [3:0] operand_reg, // register designation field
  output logic [7:0] absolute_address_field, // absolute address
  output logic alt_select // fourth_byte_high_nibble msb
);
  logic [3:0] fourth_byte_high_nibble;
  always_comb
  begin
    fourth_byte_high_nibble = fourth_byte[7:4];
    is_reg_indirect = (first_byte == isc_pkg::ISC_OP_REG_IND_LO) ||
                      (first_byte == isc_pkg::ISC_OP_REG_IND_HI);
    is_absolute = (first_byte == isc_pkg::ISC_OP_ABS_LO) ||
                  (first_byte == isc_pkg::ISC_OP_ABS_HI);
    operand_reg = second_byte[isc_pkg::ISC_REG_FIELD_MSB:isc_pkg::ISC_REG_FIELD_LSB];
    absolute_address_field = second_byte;
    alt_select = fourth_byte_high_nibble[3];
  end
endmodule

// *** rtl/isc_counter.sv ***
// instruction state counter: totals and paces the cycles of one instruction
module isc_counter #(
  parameter int CNT_W = isc_pkg::ISC_CNT_W, // cycles per category width
  parameter int STATES_W = isc_pkg::ISC_STATES_W // total states width
) (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic start, // load new instruction (same clock)
  input wire logic [CNT_W-1:0] n_fetch, // fetch cycles
  input wire logic [CNT_W-1:0] n_branch, // branch address reads
  input wire logic [CNT_W-1:0] n_stack, // stack operations
  input wire logic [CNT_W-1:0] n_byte, // byte data accesses
  input wire logic [CNT_W-1:0] n_word, // word data accesses
  input wire logic [CNT_W-1:0] n_internal, // internal operations
  input wire logic data_periph, // data accesses target a peripheral
  input wire logic periph_slow, // addressed peripheral needs 3 states
  input wire logic [7:0] first_byte, // opcode first byte
  input wire logic [7:0] second_byte, // opcode second byte
  input wire logic [7:0] fourth_byte, // opcode fourth byte
  output logic busy, // instruction executing
  output logic ready, // may accept next instruction
  output logic done, // one-cycle pulse at instruction end
  output logic [STATES_W-1:0] total_states, // computed total
  output logic [STATES_W-1:0] elapsed_states, // states counted so far
  output logic dec_reg_indirect, // registered decode: reg-indirect form
  output logic dec_absolute, // registered decode: absolute form
  output logic [3:0] dec_operand_reg, // registered register field
  output logic [7:0] dec_abs_addr, // registered absolute address
  output logic dec_alt_select // registered instruction select
);
  // worst case sum is 13 times the largest count, so four extra bits are needed
  if (CNT_W < 1 || STATES_W < CNT_W + 4)
  begin : g_width_check
    $error("isc_counter: widths too small");
  end

  typedef enum logic [0:0] {ISC_IDLE, ISC_RUN} isc_state_t;

  // ************************************************
  // decode
  // ************************************************
  logic d_ri, d_ab, d_alt;
  logic [3:0] d_reg;
  logic [7:0] d_addr;
  isc_decode u_decode (
    .first_byte(first_byte),
    .second_byte(second_byte),
    .fourth_byte(fourth_byte),
    .is_reg_indirect(d_ri),
    .is_absolute(d_ab),
    .operand_reg(d_reg),
    .absolute_address_field(d_addr),
    .alt_select(d_alt)
  );

  // ************************************************
  // state cost and sum
  // ************************************************
  logic [1:0] data_cost;
  logic [STATES_W-1:0] sum;
  always_comb
  begin
    // peripheral wait depends on the module, so the caller supplies the selection
    if (data_periph)
      data_cost = periph_slow ? isc_pkg::ISC_COST_PERIPH_SLOW : isc_pkg::ISC_COST_PERIPH_FAST;
    else
      data_cost = isc_pkg::ISC_COST_MEM;
    sum = STATES_W'(n_fetch) * STATES_W'(isc_pkg::ISC_COST_MEM)
        + STATES_W'(n_branch) * STATES_W'(isc_pkg::ISC_COST_MEM)
        + STATES_W'(n_stack) * STATES_W'(isc_pkg::ISC_COST_MEM)
        + STATES_W'(n_byte) * STATES_W'(data_cost)
        + STATES_W'(n_word) * STATES_W'(data_cost)
        + STATES_W'(n_internal) * STATES_W'(isc_pkg::ISC_COST_INTERNAL);
  end

  // ************************************************
  // pacing
  // ************************************************
  isc_state_t state_reg, state_next;
  logic [STATES_W-1:0] total_reg, total_next, elapsed_reg, elapsed_next;
  logic done_reg, done_next;
  logic busy_reg, busy_next, ready_reg, ready_next;
  logic ri_reg, ri_next, ab_reg, ab_next, alt_reg, alt_next;
  logic [3:0] oreg_reg, oreg_next;
  logic [7:0] addr_reg, addr_next;

  always_comb
  begin
    state_next = state_reg;
    total_next = total_reg;
    elapsed_next = elapsed_reg;
    done_next = 1'b0;
    ri_next = ri_reg;
    ab_next = ab_reg;
    alt_next = alt_reg;
    oreg_next = oreg_reg;
    addr_next = addr_reg;
    case (state_reg)
      ISC_IDLE:
      begin
        // start while running is ignored, so the next instruction waits
        if (start && sum != '0)
        begin
          state_next = ISC_RUN;
          total_next = sum;
          elapsed_next = '0;
          ri_next = d_ri;
          ab_next = d_ab;
          alt_next = d_alt;
          oreg_next = d_reg;
          addr_next = d_addr;
        end
      end
      ISC_RUN:
      begin
        elapsed_next = elapsed_reg + 1'b1;
        if (elapsed_reg + 1'b1 == total_reg)
        begin
          state_next = ISC_IDLE;
          done_next = 1'b1;
        end
      end
      default: state_next = ISC_IDLE;
    endcase
    // registered flags keep both outputs straight off flip-flops
    busy_next = (state_next == ISC_RUN);
    ready_next = (state_next == ISC_IDLE);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ISC_IDLE;
      total_reg <= '0;
      elapsed_reg <= '0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      ready_reg <= 1'b1;
      ri_reg <= 1'b0;
      ab_reg <= 1'b0;
      alt_reg <= 1'b0;
      oreg_reg <= 4'h0;
      addr_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      total_reg <= total_next;
      elapsed_reg <= elapsed_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      ready_reg <= ready_next;
      ri_reg <= ri_next;
      ab_reg <= ab_next;
      alt_reg <= alt_next;
      oreg_reg <= oreg_next;
      addr_reg <= addr_next;
    end
  end

  assign busy = busy_reg;
  assign ready = ready_reg;
  assign done = done_reg;
  assign total_states = total_reg;
  assign elapsed_states = elapsed_reg;
  assign dec_reg_indirect = ri_reg;
  assign dec_absolute = ab_reg;
  assign dec_operand_reg = oreg_reg;
  assign dec_abs_addr = addr_reg;
  assign dec_alt_select = alt_reg;

  // ************************************************
  // checks
  // ************************************************
  a_load_total: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && sum != '0) |=> (total_states == $past(sum) && busy))
    else $error("total not loaded from sum");
  a_fetch_cost: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && n_fetch == 4'(2) && n_branch == '0 && n_stack == '0 && n_byte == '0
     && n_word == '0 && n_internal == '0) |=> (total_states == STATES_W'(4)))
    else $error("fetch cost wrong");
  a_ram_cost: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && !data_periph && n_fetch == '0 && n_branch == '0 && n_stack == '0
     && n_byte == 4'(1) && n_word == 4'(1) && n_internal == '0) |=> (total_states == STATES_W'(4)))
    else $error("ram data cost wrong");
  a_branch_stack: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && n_fetch == '0 && n_branch == 4'(1) && n_stack == 4'(1) && n_byte == '0
     && n_word == '0 && n_internal == '0) |=> (total_states == STATES_W'(4)))
    else $error("branch or stack cost wrong");
  a_periph_slow: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && data_periph && periph_slow && n_fetch == '0 && n_branch == '0
     && n_stack == '0 && n_byte == 4'(1) && n_word == '0 && n_internal == '0)
    |=> (total_states == STATES_W'(3)))
    else $error("slow peripheral cost wrong");
  a_internal_cost: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && n_fetch == '0 && n_branch == '0 && n_stack == '0 && n_byte == '0
     && n_word == '0 && n_internal == 4'(3)) |=> (total_states == STATES_W'(3)))
    else $error("internal cost wrong");
  a_hold_next: assert property (@(posedge mclk) disable iff (!reset_n)
    (busy && !done_next) |=> (busy && total_states == $past(total_states)))
    else $error("instruction ended early");
  a_done_at_end: assert property (@(posedge mclk) disable iff (!reset_n)
    done |-> (ready && elapsed_states == total_states && total_states != '0))
    else $error("done not at end");
  a_decode_field: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && sum != '0) |=> (dec_operand_reg == $past(second_byte[7:4])
     && dec_abs_addr == $past(second_byte) && dec_alt_select == $past(fourth_byte[7])))
    else $error("decode fields wrong");
  a_periph_fast: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && data_periph && !periph_slow && n_fetch == '0 && n_branch == '0
     && n_stack == '0 && n_byte == '0 && n_word == 4'(1) && n_internal == '0)
    |=> (total_states == STATES_W'(2)))
    else $error("fast peripheral cost wrong");
  a_zero_refused: assert property (@(posedge mclk) disable iff (!reset_n)
    (ready && start && sum == '0) |=> ready)
    else $error("zero sum instruction accepted");
  a_done_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    done |=> !done)
    else $error("done longer than one cycle");
endmodule

// *** verification/isc_periph_model.sv ***
// behavioural model of the on-chip peripheral modules: per-module wait selection
module isc_periph_model (
  input wire logic [1:0] module_sel, // addressed peripheral module
  output logic periph_slow // module needs 3 states
);
  timeunit 1ns;
  timeprecision 1ns;
  // modules 2 and 3 are slow, 0 and 1 fast; the split is arbitrary
  assign periph_slow = module_sel[1];
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the instruction state counter
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [23:0] cnt; logic per; logic [1:0] sel; logic [23:0] op; logic [7:0] tot;} isc_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic data_periph = 1'b0;
  logic [1:0] module_sel = 2'h0;
  logic [23:0] cnt = 24'h000000;
  logic [23:0] op = 24'h000000;
  logic periph_slow, busy, ready, done, d_ri, d_ab, d_alt;
  logic [7:0] total_states, elapsed_states, d_addr;
  logic [3:0] d_reg;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  isc_row_t rows [13];
  always #5 mclk = ~mclk;
  isc_periph_model partner (.module_sel(module_sel), .periph_slow(periph_slow));
  isc_counter dut (.mclk(mclk), .reset_n(reset_n), .start(start), .n_fetch(cnt[23:20]), .n_branch(cnt[19:16]),
    .n_stack(cnt[15:12]), .n_byte(cnt[11:8]), .n_word(cnt[7:4]), .n_internal(cnt[3:0]),
    .data_periph(data_periph), .periph_slow(periph_slow), .first_byte(op[23:16]), .second_byte(op[15:8]),
    .fourth_byte(op[7:0]), .busy(busy), .ready(ready), .done(done), .total_states(total_states),
    .elapsed_states(elapsed_states), .dec_reg_indirect(d_ri), .dec_absolute(d_ab), .dec_operand_reg(d_reg),
    .dec_abs_addr(d_addr), .dec_alt_select(d_alt));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // entered at a falling edge; leaves at the falling edge where done is high
  task automatic run(input isc_row_t r);
    int k;
    cnt = r.cnt;
    op = r.op;
    data_periph = r.per;
    module_sel = r.sel;
    start = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    // start stays high with other values: must be ignored while busy
    cnt = 24'h111111;
    op = ~r.op;
    k = 0;
    while (done !== 1'b1 && k < 300)
    begin
      chk({7'h00, busy}, 8'h01);
      @(negedge mclk);
      k++;
    end
    chk(8'(k), r.tot);
    chk(total_states, r.tot);
    chk(elapsed_states, r.tot);
    chk({6'h00, d_ri, d_ab}, {6'h00, r.op[23:17] == 7'h3E, r.op[23:17] == 7'h3F});
    chk({4'h0, d_reg}, {4'h0, r.op[15:12]});
    chk(d_addr, r.op[15:8]);
    chk({7'h00, d_alt}, {7'h00, r.op[7]});
    $display("test row done, states %0d", r.tot);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    rows[0] = '{24'h200200, 1'b0, 2'h0, 24'h7C5A80, 8'h08};
    rows[1] = '{24'h211000, 1'b0, 2'h0, 24'h7DA300, 8'h08};
    rows[2] = '{24'h100003, 1'b0, 2'h0, 24'h7E447F, 8'h05};
    rows[3] = '{24'h100110, 1'b1, 2'h1, 24'h7FC8F0, 8'h06};
    rows[4] = '{24'h100120, 1'b1, 2'h2, 24'h011280, 8'h0B};
    rows[5] = '{24'hFFFFFF, 1'b1, 2'h3, 24'h7CFF00, 8'hC3};
    rows[6] = '{24'h100000, 1'b0, 2'h3, 24'h7E0080, 8'h02};
    rows[7] = '{24'h200000, 1'b0, 2'h0, 24'h7D3000, 8'h04};
    rows[8] = '{24'h000110, 1'b0, 2'h0, 24'h7F1280, 8'h04};
    rows[9] = '{24'h011000, 1'b0, 2'h0, 24'h7C0000, 8'h04};
    rows[10] = '{24'h000100, 1'b1, 2'h2, 24'h55AA80, 8'h03};
    rows[11] = '{24'h000010, 1'b1, 2'h1, 24'h7E9C00, 8'h02};
    rows[12] = '{24'h000003, 1'b0, 2'h0, 24'h7DF87F, 8'h03};
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    chk({6'h00, busy, ready}, 8'h01);
    chk(total_states, 8'h00);
    // back to back: each row starts in the cycle its predecessor ends
    foreach (rows[i])
      run(rows[i]);
    start = 1'b0;
    @(negedge mclk);
    cnt = 24'h000000;
    start = 1'b1;
    repeat (3) @(negedge mclk);
    chk({7'h00, busy}, 8'h00);
    $display("test zero sum done");
    cnt = 24'h333333;
    repeat (3) @(negedge mclk);
    chk({7'h00, busy}, 8'h01);
    reset_n = 1'b0;
    start = 1'b0;
    @(negedge mclk);
    chk({5'h00, busy, ready, done}, 8'h02);
    chk(total_states, 8'h00);
    reset_n = 1'b1;
    @(negedge mclk);
    run(rows[6]);
    $display("test reset in mid run done");
    final_report();
  end
endmodule
